//--- verilog/seess_host.sv
`timescale 1ns/1ps
// Functional notes
// RULE1: sector erase is six writes: AA, 55, 80, AA, 55, sector address with 30
// RULE2: device preprograms and verifies sector itself; host sends no extra control
// RULE3: device opens a 50 us window after last write strobe rising edge
// RULE4: extra sector writes with 30 accepted inside window in any order
// RULE5: host keeps gap between extra sector writes below 50 us; host has no timer for it, ADD_GAP_CYC is unused
// RULE6: other write in window aborts to read; host must reissue whole request
// RULE7: device shows window expiry on erase_window_flag
// RULE8: during erasure device takes only suspend, ignores other writes
// RULE9: hardware reset aborts erase; host reissues after read mode returns
// RULE10: on completion device returns to read; progress on status bits, ready_busy
// RULE11: suspend honoured only in sector erase, ignored in chip erase or program
// RULE12: suspend takes effect within 20 us, at once inside window
// RULE13: suspended device reads and programs unselected sectors, status in selected
// RULE14: polling or toggle bits distinguish erasing from suspended sectors
// RULE15: after suspended program, array data returns for unselected sectors
// RULE16: identification read allowed in suspend; leaving it returns to suspend
// RULE17: resume code with any address continues erase; repeats ignored
// RULE18: suspend is one write of B0, address ignored
// RULE19: secure entry AA,55,88; exit AA,55,90,00
// RULE20: identification read AA,55,90 then read at offset zero for maker code
// RULE21: single reset write F0 at any address returns device to read mode
// RULE22: host writes reset to leave identification mode
// RULE23: device flags each accepted sector and erases exactly those
module seess_host
   import seess_pkg::*;
(
   input  wire logic              CLK_I,
   input  wire logic              RSTN_I,
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [7:0]        PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   output logic      [31:0]       PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   output logic      [ADDR_W-1:0] FLASH_ADDR_O,
   output logic      [DATA_W-1:0] FLASH_DQ_O,
   output logic                   FLASH_DQ_OE_O,
   input  wire logic [DATA_W-1:0] FLASH_DQ_I,
   output logic                   FLASH_WE_N_O,
   output logic                   FLASH_OE_N_O,
   output logic                   FLASH_CE_N_O,
   output logic                   FLASH_RESET_N_O,
   input  wire logic              READY_BUSY_I
);

   // ----------------------------------------------------------------
   // sequence selection
   // ----------------------------------------------------------------
   localparam int SEQ_MAX = 6;

   typedef enum {
      S_IDLE,
      S_CYCLE,
      S_HWRST
   } seess_state_type;

   seess_state_type              state, next_state;
   seess_phase_type              phase, next_phase;
   seess_cycle_type              seq [SEQ_MAX];
   logic            [2:0]        seq_len;
   logic            [2:0]        idx, next_idx;
   logic            [2:0]        tick, next_tick;
   logic            [15:0]       gap_cnt, next_gap_cnt;
   logic            [3:0]        op, next_op;
   logic            [ADDR_W-1:0] op_addr, next_op_addr;
   logic            [DATA_W-1:0] op_data, next_op_data;
   logic                         busy, next_busy;
   logic                         done, next_done;
   logic                         err, next_err;
   logic            [DATA_W-1:0] rdata, next_rdata;
   logic            [31:0]       prdata, next_prdata;
   logic                         pready, next_pready;
   logic                         pslverr, next_pslverr;
   logic            [ADDR_W-1:0] f_addr, next_f_addr;
   logic            [DATA_W-1:0] f_dq, next_f_dq;
   logic                         f_oe, next_f_oe;
   logic                         f_we_n, next_f_we_n;
   logic                         f_oe_n, next_f_oe_n;
   logic                         f_ce_n, next_f_ce_n;
   logic                         f_rst_n, next_f_rst_n;
   logic                         apb_acc, cmd_wr, is_read;

   // ----------------------------------------------------------------
   // command table per operation
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < SEQ_MAX; i++) begin
         seq[i] = '{wr: 1'b1, addr: '0, data: CMD_NONE};
      end
      seq[0].data = CMD_UNLOCK1;
      seq[1].data = CMD_UNLOCK2;
      seq_len     = 3'h1;
      case (op)
         OP_SECT_ERASE, OP_CHIP_ERASE: begin
            seq[2].data = CMD_SETUP;   // RULE1
            seq[3].data = CMD_UNLOCK1;
            seq[4].data = CMD_UNLOCK2;
            seq[5]      = '{wr: 1'b1, addr: op_addr,
                            data: (op == OP_SECT_ERASE) ? CMD_SECT_ERASE : CMD_CHIP_ERASE};
            seq_len     = 3'h6;
         end
         OP_ADD_SECTOR: seq[0] = '{wr: 1'b1, addr: op_addr, data: CMD_SECT_ERASE}; // RULE5
         OP_SUSPEND:    seq[0] = '{wr: 1'b1, addr: '0, data: CMD_SUSPEND}; // RULE18
         OP_RESUME:     seq[0] = '{wr: 1'b1, addr: '0, data: CMD_RESUME}; // RULE17
         OP_RESET:      seq[0] = '{wr: 1'b1, addr: '0, data: CMD_RESET}; // RULE21 RULE22
         OP_QUERY:      seq[0] = '{wr: 1'b1, addr: '0, data: CMD_QUERY};
         OP_AUTOSEL: begin
            seq[2].data = CMD_AUTOSEL; // RULE20 RULE16
            seq[3]      = '{wr: 1'b0, addr: ID_MAKER_ADDR, data: CMD_NONE};
            seq_len     = 3'h4;
         end
         OP_SECURE_IN: begin
            seq[2].data = CMD_SECURE_IN; // RULE19
            seq_len     = 3'h3;
         end
         OP_SECURE_OUT: begin
            seq[2].data = CMD_AUTOSEL; // RULE19
            seq[3].data = CMD_EXIT2;
            seq_len     = 3'h4;
         end
         OP_BYPASS: begin
            seq[2].data = CMD_BYPASS;
            seq_len     = 3'h3;
         end
         OP_PROGRAM: begin
            seq[2].data = CMD_PROGRAM; // RULE13 RULE15
            seq[3]      = '{wr: 1'b1, addr: op_addr, data: op_data};
            seq_len     = 3'h4;
         end
         OP_READ:       seq[0] = '{wr: 1'b0, addr: op_addr, data: CMD_NONE};
         default:       seq_len = 3'h1;
      endcase
   end

   // ----------------------------------------------------------------
   // apb slave and sequencer
   // ----------------------------------------------------------------
   assign apb_acc = PSEL_I && PENABLE_I && !pready;
   assign cmd_wr  = apb_acc && PWRITE_I && (PADDR_I == REG_CMD);
   assign is_read = !seq[idx].wr;

   always_comb begin
      next_state   = state;
      next_phase   = phase;
      next_idx     = idx;
      next_tick    = tick;
      next_gap_cnt = gap_cnt;
      next_op      = op;
      next_op_addr = op_addr;
      next_op_data = op_data;
      next_busy    = busy;
      next_done    = done;
      next_err     = err;
      next_rdata   = rdata;
      next_prdata  = prdata;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      next_f_addr  = f_addr;
      next_f_dq    = f_dq;
      next_f_oe    = f_oe;
      next_f_we_n  = f_we_n;
      next_f_oe_n  = f_oe_n;
      next_f_ce_n  = f_ce_n;
      next_f_rst_n = f_rst_n;
      if (apb_acc) begin
         next_pready = 1'b1;
         if (PWRITE_I) begin
            case (PADDR_I)
               REG_CMD: begin
                  if (busy) begin
                     next_err = 1'b1;
                  end else begin
                     next_op = PWDATA_I[3:0];
                  end
               end
               REG_ADDR: next_op_addr = PWDATA_I[ADDR_W-1:0];
               REG_DATA: next_op_data = PWDATA_I[DATA_W-1:0];
               REG_STATUS: begin
                  next_done = 1'b0;
                  next_err  = 1'b0;
               end
               default: next_pslverr = 1'b1;
            endcase
         end else begin
            case (PADDR_I)
               REG_CMD:    next_prdata = {28'h0000000, op};
               REG_ADDR:   next_prdata = {10'h000, op_addr};
               REG_DATA:   next_prdata = {24'h000000, op_data};
               REG_STATUS: next_prdata = {28'h0000000, READY_BUSY_I, err, done, busy};
               REG_RDATA:  next_prdata = {24'h000000, rdata};
               default: begin
                  next_prdata  = RESET_WORD;
                  next_pslverr = 1'b1;
               end
            endcase
         end
      end
      case (state)
         S_IDLE: begin
            if (cmd_wr && !busy) begin
               next_busy = 1'b1;
               next_done = 1'b0;
               next_idx  = 3'h0;
               next_tick = 3'h0;
               if (PWDATA_I[3:0] == OP_HW_RESET) begin
                  next_state   = S_HWRST; // RULE9
                  next_gap_cnt = 16'h0000;
                  next_f_rst_n = 1'b0;
               end else begin
                  next_state = S_CYCLE;
                  next_phase = SEESS_PH_IDLE;
               end
            end
         end
         S_CYCLE: begin
            case (phase)
               SEESS_PH_IDLE: begin
                  next_f_addr = seq[idx].addr;
                  next_f_dq   = seq[idx].data;
                  next_f_oe   = seq[idx].wr;
                  next_f_ce_n = 1'b0;
                  next_f_we_n = !seq[idx].wr;
                  next_f_oe_n = seq[idx].wr;
                  next_tick   = 3'h0;
                  next_phase  = SEESS_PH_LOW;
               end
               SEESS_PH_LOW: begin
                  next_tick = tick + 3'h1;
                  if (tick == STROBE_LOW_CYC) begin
                     if (is_read) begin
                        next_rdata = FLASH_DQ_I;
                     end
                     next_f_we_n = 1'b1;
                     next_f_oe_n = 1'b1;
                     next_tick   = 3'h0;
                     next_phase  = SEESS_PH_HIGH;
                  end
               end
               SEESS_PH_HIGH: begin
                  next_tick = tick + 3'h1;
                  if (tick == STROBE_HIGH_CYC) begin
                     next_f_ce_n = 1'b1;
                     next_f_oe   = 1'b0;
                     next_phase  = SEESS_PH_IDLE;
                     if (idx == seq_len - 3'h1) begin
                        next_state = S_IDLE; // RULE2 RULE10
                        next_busy  = 1'b0;
                        next_done  = 1'b1;
                     end else begin
                        next_idx = idx + 3'h1; // RULE6
                     end
                  end
               end
               default: next_phase = SEESS_PH_IDLE;
            endcase
         end
         S_HWRST: begin
            next_gap_cnt = gap_cnt + 16'h0001;
            if (gap_cnt == 16'(HW_RESET_CYC)) begin
               next_f_rst_n = 1'b1;
               next_state   = S_IDLE;
               next_busy    = 1'b0;
               next_done    = 1'b1;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state   <= S_IDLE;
         phase   <= SEESS_PH_IDLE;
         idx     <= 3'h0;
         tick    <= 3'h0;
         gap_cnt <= 16'h0000;
         op      <= 4'h0;
         op_addr <= '0;
         op_data <= '0;
         busy    <= 1'b0;
         done    <= 1'b0;
         err     <= 1'b0;
         rdata   <= '0;
         prdata  <= RESET_WORD;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         f_addr  <= '0;
         f_dq    <= '0;
         f_oe    <= 1'b0;
         f_we_n  <= 1'b1;
         f_oe_n  <= 1'b1;
         f_ce_n  <= 1'b1;
         f_rst_n <= 1'b1;
      end else begin
         state   <= next_state;
         phase   <= next_phase;
         idx     <= next_idx;
         tick    <= next_tick;
         gap_cnt <= next_gap_cnt;
         op      <= next_op;
         op_addr <= next_op_addr;
         op_data <= next_op_data;
         busy    <= next_busy;
         done    <= next_done;
         err     <= next_err;
         rdata   <= next_rdata;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         f_addr  <= next_f_addr;
         f_dq    <= next_f_dq;
         f_oe    <= next_f_oe;
         f_we_n  <= next_f_we_n;
         f_oe_n  <= next_f_oe_n;
         f_ce_n  <= next_f_ce_n;
         f_rst_n <= next_f_rst_n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign PRDATA_O        = prdata;
   assign PREADY_O        = pready;
   assign PSLVERR_O       = pslverr;
   assign FLASH_ADDR_O    = f_addr;
   assign FLASH_DQ_O      = f_dq;
   assign FLASH_DQ_OE_O   = f_oe;
   assign FLASH_WE_N_O    = f_we_n;
   assign FLASH_OE_N_O    = f_oe_n;
   assign FLASH_CE_N_O    = f_ce_n;
   assign FLASH_RESET_N_O = f_rst_n;

endmodule : seess_host

//--- verilog/seess_pkg.sv
package seess_pkg;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_UNLOCK1     = 8'hAA;
   localparam logic [7:0] CMD_UNLOCK2     = 8'h55;
   localparam logic [7:0] CMD_SETUP       = 8'h80;
   localparam logic [7:0] CMD_SECT_ERASE  = 8'h30;
   localparam logic [7:0] CMD_CHIP_ERASE  = 8'h10;
   localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
   localparam logic [7:0] CMD_RESUME      = 8'h30;
   localparam logic [7:0] CMD_AUTOSEL     = 8'h90;
   localparam logic [7:0] CMD_SECURE_IN   = 8'h88;
   localparam logic [7:0] CMD_EXIT2       = 8'h00;
   localparam logic [7:0] CMD_PROGRAM     = 8'hA0;
   localparam logic [7:0] CMD_BYPASS      = 8'h20;
   localparam logic [7:0] CMD_RESET       = 8'hF0;
   localparam logic [7:0] CMD_QUERY       = 8'h98;
   localparam logic [7:0] CMD_NONE        = 8'h00;

   // ----------------------------------------------------------------
   // host operation codes
   // ----------------------------------------------------------------
   localparam logic [3:0] OP_SECT_ERASE   = 4'h1;
   localparam logic [3:0] OP_ADD_SECTOR   = 4'h2;
   localparam logic [3:0] OP_SUSPEND      = 4'h3;
   localparam logic [3:0] OP_RESUME       = 4'h4;
   localparam logic [3:0] OP_AUTOSEL      = 4'h5;
   localparam logic [3:0] OP_SECURE_IN    = 4'h6;
   localparam logic [3:0] OP_SECURE_OUT   = 4'h7;
   localparam logic [3:0] OP_RESET        = 4'h8;
   localparam logic [3:0] OP_PROGRAM      = 4'h9;
   localparam logic [3:0] OP_READ         = 4'hA;
   localparam logic [3:0] OP_HW_RESET     = 4'hB;
   localparam logic [3:0] OP_CHIP_ERASE   = 4'hC;
   localparam logic [3:0] OP_QUERY        = 4'hD;
   localparam logic [3:0] OP_BYPASS       = 4'hE;

   // ----------------------------------------------------------------
   // apb register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CMD         = 8'h00;
   localparam logic [7:0] REG_ADDR        = 8'h04;
   localparam logic [7:0] REG_DATA        = 8'h08;
   localparam logic [7:0] REG_STATUS      = 8'h0C;
   localparam logic [7:0] REG_RDATA       = 8'h10;
   localparam int         ST_BUSY_BIT     = 0;
   localparam int         ST_DONE_BIT     = 1;
   localparam int         ST_ERR_BIT      = 2;
   localparam int         ST_RYBY_BIT     = 3;
   localparam logic [31:0] RESET_WORD     = 32'h0000_0000;

   // ----------------------------------------------------------------
   // bus widths and timing
   // ----------------------------------------------------------------
   localparam int ADDR_W                  = 22;
   localparam int DATA_W                  = 8;
   localparam int CLK_HZ                  = 10_000_000;
   localparam int WINDOW_US               = 50;
   localparam int WINDOW_CYC              = WINDOW_US * (CLK_HZ / 1_000_000);
   localparam int ADD_GAP_CYC             = (WINDOW_CYC * 4) / 5;
   localparam int SUSPEND_US              = 20;
   localparam int SUSPEND_CYC             = SUSPEND_US * (CLK_HZ / 1_000_000);
   localparam int HW_RESET_CYC            = 5;
   localparam logic [2:0] STROBE_LOW_CYC  = 3'h2;
   localparam logic [2:0] STROBE_HIGH_CYC = 3'h2;
   localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 22'h000000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } seess_cycle_type;

   typedef enum logic [1:0] {
      SEESS_PH_IDLE,
      SEESS_PH_LOW,
      SEESS_PH_HIGH
   } seess_phase_type;

endpackage : seess_pkg

//--- bench/seess_flash_model.sv
`timescale 1ns/1ps
// ------
// flash device model
// ------
module seess_flash_model #(
   parameter logic [7:0] MAKER    = 8'h3C, // arbitrary value
   parameter logic [7:0] SUS_STAT = 8'h80,
   parameter int         ERASE_US = 300
) (
   input  wire logic [21:0] addr_i,
   input  wire logic [7:0]  dq_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        ce_n_i,
   input  wire logic        reset_n_i,
   output logic      [7:0]  dq_o,
   output logic             ready_busy_o
);
   localparam int RD = 0, WIN = 1, ERS = 2, SUS = 3;
   logic [29:0] wlog[$];
   logic [39:0] hist = '0;
   logic [63:0] sel  = '0;
   logic [7:0]  rd;
   int          st   = RD;
   int          tmr  = 0;
   bit          id   = 0;
   always @(posedge we_n_i) begin
      if (!ce_n_i && reset_n_i) begin
         wlog.push_back({addr_i, dq_i});
         if (st == WIN) begin
            tmr = 0;
            if (dq_i == 8'h30) sel[addr_i[21:16]] = 1'b1;
            else if (dq_i == 8'hB0) st = SUS;
            else begin
               st = RD;
               sel = '0;
            end
         end else if (st == ERS) begin
            if (dq_i == 8'hB0) st = SUS;
         end else if (dq_i == 8'hF0) id = 0;
         else if (st == SUS && !id && dq_i == 8'h30) st = ERS;
         else if ({hist[15:0], dq_i} == 24'hAA5590) id = 1;
         else if (st == RD && {hist, dq_i} == 48'hAA5580AA5530) begin
            st = WIN;
            tmr = 0;
            sel[addr_i[21:16]] = 1'b1;
         end
         hist = {hist[31:0], dq_i};
      end
   end
   always #1us begin
      tmr++;
      if (st == WIN && tmr >= 50) begin
         st = ERS;
         tmr = 0;
      end
      if (st == ERS && tmr >= ERASE_US) begin
         st = RD;
         sel = '0;
      end
   end
   always @(negedge reset_n_i) begin
      st = RD;
      sel = '0;
      id = 0;
   end
   always_comb begin
      if (id) rd = (addr_i[7:0] == 8'h00) ? MAKER : 8'h00;
      else if (st == SUS && sel[addr_i[21:16]]) rd = SUS_STAT;
      else rd = addr_i[7:0];
   end
   assign dq_o = (!oe_n_i && !ce_n_i) ? rd : ~rd;
   assign ready_busy_o = !(st == WIN || st == ERS);
endmodule : seess_flash_model

//--- bench/seess_host_properties.sv
`timescale 1ns/1ps
module seess_host_properties
   import seess_pkg::*;
(
   input wire logic              CLK_I,
   input wire logic              RSTN_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PREADY_O,
   input wire logic              PSLVERR_O,
   input wire logic [ADDR_W-1:0] FLASH_ADDR_O,
   input wire logic [DATA_W-1:0] FLASH_DQ_O,
   input wire logic              FLASH_DQ_OE_O,
   input wire logic              FLASH_WE_N_O,
   input wire logic              FLASH_OE_N_O,
   input wire logic              FLASH_CE_N_O,
   input wire logic              FLASH_RESET_N_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
      else $error("pready held too long");
   chk_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
      else $error("pready late");
   chk_err_with_ready: assert property (PSLVERR_O |-> PREADY_O && PSEL_I)
      else $error("pslverr without pready");
   chk_we_width: assert property ($fell(FLASH_WE_N_O) |-> !FLASH_WE_N_O[*3] ##1 FLASH_WE_N_O)
      else $error("write strobe width wrong");
   chk_we_framed: assert property (!FLASH_WE_N_O |-> !FLASH_CE_N_O && FLASH_DQ_OE_O)
      else $error("write strobe outside select");
   chk_addr_stable: assert property (!FLASH_CE_N_O && $past(!FLASH_CE_N_O) |-> $stable(FLASH_ADDR_O))
      else $error("address moved in cycle");
   chk_data_stable: assert property (!FLASH_WE_N_O && $past(!FLASH_WE_N_O) |-> $stable(FLASH_DQ_O))
      else $error("data moved in write");
   chk_no_fight: assert property (!FLASH_OE_N_O |-> !FLASH_DQ_OE_O && FLASH_WE_N_O)
      else $error("bus contention");
   chk_reset_width: assert property ($fell(FLASH_RESET_N_O) |-> !FLASH_RESET_N_O[*5] ##[1:3] FLASH_RESET_N_O)
      else $error("reset pulse width wrong");
   cover property ($fell(FLASH_WE_N_O) && FLASH_DQ_O == CMD_SUSPEND);
   cover property ($fell(FLASH_WE_N_O) && FLASH_DQ_O == CMD_SECT_ERASE);
   cover property ($fell(FLASH_RESET_N_O));
   cover property (PSLVERR_O);
endmodule : seess_host_properties
bind seess_host seess_host_properties i_props (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE_O(FLASH_DQ_OE_O),
   .FLASH_WE_N_O(FLASH_WE_N_O), .FLASH_OE_N_O(FLASH_OE_N_O), .FLASH_CE_N_O(FLASH_CE_N_O),
   .FLASH_RESET_N_O(FLASH_RESET_N_O));

//--- bench/seess_host_tb.sv
`timescale 1ns/1ps
module seess_host_tb
   import seess_pkg::*;
;
   localparam logic [7:0] MAKER    = 8'h3C; // arbitrary value
   localparam logic [7:0] SUS_STAT = 8'h80;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr, rerr;
   logic        dq_oe, we_n, oe_n, ce_n, frst_n, ryby;
   logic [7:0]  paddr, dq_h, dq_d, dq_bus;
   logic [31:0] pwdata, prdata, rdat;
   logic [21:0] faddr;
   int          errors = 0, check_count = 0, rst_seen = 0;
   assign dq_bus = dq_oe ? dq_h : dq_d;
   seess_host i_dut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .FLASH_ADDR_O(faddr), .FLASH_DQ_O(dq_h),
      .FLASH_DQ_OE_O(dq_oe), .FLASH_DQ_I(dq_bus), .FLASH_WE_N_O(we_n), .FLASH_OE_N_O(oe_n),
      .FLASH_CE_N_O(ce_n), .FLASH_RESET_N_O(frst_n), .READY_BUSY_I(ryby));
   seess_flash_model #(.MAKER(MAKER), .SUS_STAT(SUS_STAT)) i_flash (.addr_i(faddr),
      .dq_i(dq_bus), .we_n_i(we_n), .oe_n_i(oe_n), .ce_n_i(ce_n), .reset_n_i(frst_n),
      .dq_o(dq_d), .ready_busy_o(ryby));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(negedge frst_n) rst_seen++;
   // ------
   // helpers
   // ------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic do_op(input logic [3:0] op);
      apb(1'b1, REG_CMD, {28'h0, op});
      do begin
         apb(1'b0, REG_STATUS, '0);
      end while (rdat[ST_DONE_BIT] !== 1'b1);
      apb(1'b1, REG_STATUS, '0);
   endtask : do_op
   task automatic chk_log(input int back, input logic [7:0] d);
      logic [29:0] e;
      e = i_flash.wlog[i_flash.wlog.size() - back];
      chk("flash write data", {24'h0, d}, {24'h0, e[7:0]});
   endtask : chk_log
   task automatic rd_flash(input logic [31:0] a, input logic [7:0] exp);
      apb(1'b1, REG_ADDR, a);
      do_op(OP_READ);
      apb(1'b0, REG_RDATA, '0);
      chk("read byte", {24'h0, exp}, rdat);
   endtask : rd_flash
   task automatic ryby_is(input logic exp);
      apb(1'b0, REG_STATUS, '0);
      chk("ready busy", {31'h0, exp}, {31'h0, rdat[ST_RYBY_BIT]});
   endtask : ryby_is
   // ------
   // scenarios
   // ------
   task automatic t_regs;
      apb(1'b0, REG_STATUS, '0);
      chk("status reset", 32'h8, rdat);
      apb(1'b1, REG_DATA, 32'hFFFF_FF5A);
      apb(1'b0, REG_DATA, '0);
      chk("data reg", 32'h5A, rdat);
      apb(1'b1, REG_ADDR, 32'hFFFF_FFFF);
      apb(1'b0, REG_ADDR, '0);
      chk("addr reg", 32'h003F_FFFF, rdat);
      apb(1'b0, 8'h14, '0);
      chk("unmapped err", 32'h1, {31'h0, rerr});
      $display("t_regs done");
   endtask : t_regs
   task automatic t_erase;
      logic [7:0] seq [6] = '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_SETUP, CMD_UNLOCK1,
                              CMD_UNLOCK2, CMD_SECT_ERASE};
      apb(1'b1, REG_ADDR, 32'h0003_0000);
      do_op(OP_SECT_ERASE);
      for (int i = 0; i < 6; i++) chk_log(6 - i, seq[i]);
      chk("sector addr", 32'h0003_0000, {10'h0, i_flash.wlog[$][29:8]});
      apb(1'b1, REG_ADDR, 32'h0005_0000);
      do_op(OP_ADD_SECTOR);
      chk_log(1, 8'h30);
      ryby_is(1'b0);
      do_op(OP_SUSPEND);
      chk_log(1, 8'hB0);
      rd_flash(32'h0005_0011, SUS_STAT);
      rd_flash(32'h0007_0022, 8'h22);
      do_op(OP_AUTOSEL);
      apb(1'b0, REG_RDATA, '0);
      chk("maker code", {24'h0, MAKER}, rdat);
      do_op(OP_RESET);
      chk_log(1, 8'hF0);
      do_op(OP_RESUME);
      chk_log(1, 8'h30);
      ryby_is(1'b0);
      $display("t_erase done");
   endtask : t_erase
   task automatic t_hwreset;
      int n;
      n = rst_seen;
      do_op(OP_HW_RESET);
      chk("reset pulses", 32'(n + 1), 32'(rst_seen));
      ryby_is(1'b1);
      $display("t_hwreset done");
   endtask : t_hwreset
   task automatic t_abort;
      apb(1'b1, REG_ADDR, 32'h0002_0000);
      do_op(OP_SECT_ERASE);
      do_op(OP_RESET);
      chk_log(1, 8'hF0);
      ryby_is(1'b1);
      $display("t_abort done");
   endtask : t_abort
   task automatic t_refuse;
      apb(1'b1, REG_ADDR, 32'h0001_0000);
      apb(1'b1, REG_CMD, {28'h0, OP_SECT_ERASE});
      apb(1'b1, REG_CMD, {28'h0, OP_RESET});
      apb(1'b0, REG_STATUS, '0);
      chk("busy err", 32'h1, {31'h0, rdat[ST_ERR_BIT]});
      repeat (60) @(posedge clk);
      chk_log(1, 8'h30);
      do_op(OP_RESET);
      $display("t_refuse done");
   endtask : t_refuse
   task automatic t_codes;
      logic [3:0] ops [7] = '{OP_SECURE_IN, OP_SECURE_OUT, OP_QUERY, OP_BYPASS,
                              OP_PROGRAM, OP_CHIP_ERASE, OP_RESET};
      logic [7:0] fin [7] = '{8'h88, 8'h00, 8'h98, 8'h20, 8'h5A, 8'h10, 8'hF0};
      int         cnt [7] = '{3, 4, 1, 3, 4, 6, 1};
      int         n;
      for (int i = 0; i < 7; i++) begin
         n = i_flash.wlog.size();
         do_op(ops[i]);
         chk("write count", 32'(cnt[i]), 32'(i_flash.wlog.size() - n));
         chk_log(1, fin[i]);
      end
      $display("t_codes done");
   endtask : t_codes
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      tally_and_finish;
   end
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_regs;
      t_erase;
      t_hwreset;
      t_abort;
      t_refuse;
      t_codes;
      tally_and_finish;
   end
endmodule : seess_host_tb
